/* shared/adcsq_defines.vh */
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

// Register word addresses (word index, used as is on avsAddress)
`define ADCSQ_ADDR_W         4
`define ADCSQ_REG_LEN        4'h0
`define ADCSQ_REG_START      4'h1
`define ADCSQ_REG_STATUS     4'h2
`define ADCSQ_REG_FLAGS      4'h3
`define ADCSQ_REG_IRQ_STAT   4'h4
`define ADCSQ_REG_IRQ_MASK   4'h5
`define ADCSQ_REG_MODE       4'h6

// Field positions
`define ADCSQ_LEN_LSB        0
`define ADCSQ_LEN_MSB        3
`define ADCSQ_CHAN_LSB       0
`define ADCSQ_CHAN_MSB       3
`define ADCSQ_CHAN_TOP       3
`define ADCSQ_STAT_CNT_LSB   0
`define ADCSQ_STAT_CNT_MSB   3
`define ADCSQ_STAT_CHAN_LSB  4
`define ADCSQ_STAT_CHAN_MSB  7
`define ADCSQ_STAT_BUSY      8
`define ADCSQ_MODE_NARROW    0
`define ADCSQ_MODE_HIGH      1

// Interrupt status bits
`define ADCSQ_IRQ_CONV       0
`define ADCSQ_IRQ_SEQ        1

// Sequence length codes and counts
`define ADCSQ_LEN_ZERO       4'h0
`define ADCSQ_COUNT_FULL     5'h10
`define ADCSQ_COUNT_NARROW   5'h08
`define ADCSQ_NARROW_OFFSET  4'h8
`define ADCSQ_NARROW_HALF    5'h08

// Reset values
`define ADCSQ_LEN_RST        4'h0
`define ADCSQ_CHAN_RST       4'h0
`define ADCSQ_MODE_RST       2'h0

// Conversion time in cycles of the 250 MHz clock
`define ADCSQ_CONV_CYCLES    8

`endif

/* core/adcsq_chan_step.v */
`timescale 1ns/10ps
`include "adcsq_defines.vh"

module adcsq_chan_step (
    narrowMode,
    highHalf,
    chanIn,
    chanOut
);
    input  wire       narrowMode;
    input  wire       highHalf;
    input  wire [3:0] chanIn;
    output wire [3:0] chanOut;

    wire [3:0] wideNext;
    wire [2:0] lowNext;

    assign wideNext = chanIn + 4'h1;
    assign lowNext  = chanIn[2:0] + 3'h1;

    // Wide wraps 15 to 0; narrow stays inside its bank of eight
    assign chanOut = narrowMode ? {highHalf, lowNext} : wideNext;
endmodule // adcsq_chan_step

/* core/adcsq_seq_ctrl.v */
`timescale 1ns/10ps
`include "adcsq_defines.vh"

// Notes on behaviour
// - Wide length code zero means sixteen, else n
// - Wide four-bit select picks input n of 16
// - Wide select is first channel of sequence
// - Narrow first converter maps n to n
// - Narrow second converter maps n to n+8
// - Four-bit counter tracks up to sixteen
// - Narrow mode uses the same four-bit counter, eight max
// - Counter top bit reads zero, length eight or less
// - Narrow length: zero or top bit gives eight
// - Flag set per position, cleared on start
module adcsq_seq_ctrl #(
    parameter CONV_CYCLES = `ADCSQ_CONV_CYCLES
) (
    clk,
    rst_b,
    avsAddress,
    avsRead,
    avsWrite,
    avsWriteData,
    avsReadData,
    avsWaitRequest,
    convDone,
    convStart,
    convChannel,
    seqBusy,
    irq
);
    input  wire        clk;
    input  wire        rst_b;
    input  wire [3:0]  avsAddress;
    input  wire        avsRead;
    input  wire        avsWrite;
    input  wire [31:0] avsWriteData;
    output reg  [31:0] avsReadData;
    output wire        avsWaitRequest;
    input  wire        convDone;
    output reg         convStart;
    output reg  [3:0]  convChannel;
    output wire        seqBusy;
    output wire        irq;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Conversions per sequence from length code
    function [4:0] seqCount;
        input [3:0] code;
        input       narrow;
        begin
            if (narrow) begin
                if (code == `ADCSQ_LEN_ZERO || code[3]) begin
                    seqCount = `ADCSQ_COUNT_NARROW;
                end else begin
                    seqCount = {2'h0, code[2:0]};
                end
            end else if (code == `ADCSQ_LEN_ZERO) begin
                seqCount = `ADCSQ_COUNT_FULL;
            end else begin
                seqCount = {1'b0, code};
            end
        end
    endfunction

    // Physical input for a select value
    function [3:0] mapChan;
        input [3:0] sel;
        input       narrow;
        input       high;
        begin
            if (!narrow) begin
                mapChan = sel;
            end else if (high) begin
                mapChan = {1'b0, sel[2:0]} + `ADCSQ_NARROW_OFFSET;
            end else begin
                mapChan = {1'b0, sel[2:0]};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_WAIT = 2'h2;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [3:0]  lenCode_reg;
    reg  [1:0]  mode_reg;
    reg  [3:0]  startChan_reg;
    reg  [3:0]  counter_reg;
    reg  [3:0]  counter_next;
    reg  [4:0]  total_reg;
    reg  [15:0] doneFlags_reg;
    reg  [1:0]  irqStat_reg;
    reg  [1:0]  irqMask_reg;
    reg  [7:0]  timer_reg;
    reg  [3:0]  chan_next;
    reg         convStart_next;
    reg         d1, d2, d3;
    reg         rdPend_reg;

    wire        narrow;
    wire        high;
    wire        wrStart;
    wire        rdIrq;
    wire        convEnd;
    wire        lastConv;
    wire [3:0]  stepChan;
    wire [3:0]  shownCount;

    assign narrow   = mode_reg[`ADCSQ_MODE_NARROW];
    assign high     = mode_reg[`ADCSQ_MODE_HIGH];
    assign wrStart  = avsWrite && avsAddress == `ADCSQ_REG_START;
    // Read clear only in the first, waiting cycle, so an event in
    // the accepting cycle is kept for the next read
    assign rdIrq    = avsWaitRequest && avsAddress == `ADCSQ_REG_IRQ_STAT;
    // One wait state per read lets read data come from flip-flops
    assign avsWaitRequest = avsRead && !rdPend_reg;
    assign seqBusy  = state_reg != ST_IDLE;
    assign irq      = |(irqStat_reg & irqMask_reg);

    // ------------------------------------------------------------
    // Done input synchroniser
    // ------------------------------------------------------------
    // Pin may come from analog timing outside this clock
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            d1 <= 1'b0;
            d2 <= 1'b0;
            d3 <= 1'b0;
        end else begin
            d1 <= convDone;
            d2 <= d1;
            d3 <= d2;
        end
    end

    // Rising edge once second and third stages agree high
    reg doneSeen_reg;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            doneSeen_reg <= 1'b0;
        end else if (d2 == d3) begin
            doneSeen_reg <= d3;
        end
    end

    // Either external done or internal timer ends a conversion
    assign convEnd  = state_reg == ST_WAIT &&
                      ((d2 && d3 && !doneSeen_reg) ||
                       timer_reg == CONV_CYCLES[7:0]);
    assign lastConv = {1'b0, counter_reg} + 5'h01 == total_reg;

    adcsq_chan_step adcsq_chan_step_i (
        .narrowMode (narrow),
        .highHalf   (high),
        .chanIn     (convChannel),
        .chanOut    (stepChan)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @* begin
        state_next     = state_reg;
        counter_next   = counter_reg;
        chan_next      = convChannel;
        convStart_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
            end
            ST_CONV: begin
                convStart_next = 1'b1;
                state_next     = ST_WAIT;
            end
            ST_WAIT: begin
                if (convEnd) begin
                    if (lastConv) begin
                        state_next = ST_IDLE;
                    end else begin
                        counter_next = counter_reg + 4'h1;
                        chan_next    = stepChan;
                        state_next   = ST_CONV;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Start write restarts from the selected first channel
        if (wrStart) begin
            counter_next = 4'h0;
            chan_next    = mapChan(avsWriteData[`ADCSQ_CHAN_MSB:
                                   `ADCSQ_CHAN_LSB], narrow, high);
            state_next   = ST_CONV;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg   <= ST_IDLE;
            counter_reg <= 4'h0;
            convChannel <= `ADCSQ_CHAN_RST;
            convStart   <= 1'b0;
            timer_reg   <= 8'h00;
        end else begin
            state_reg   <= state_next;
            counter_reg <= counter_next;
            convChannel <= chan_next;
            convStart   <= convStart_next;
            if (state_reg == ST_WAIT && !wrStart) begin
                timer_reg <= timer_reg + 8'h01;
            end else begin
                timer_reg <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lenCode_reg   <= `ADCSQ_LEN_RST;
            mode_reg      <= `ADCSQ_MODE_RST;
            startChan_reg <= `ADCSQ_CHAN_RST;
            total_reg     <= `ADCSQ_COUNT_FULL;
            doneFlags_reg <= 16'h0000;
            irqStat_reg   <= 2'h0;
            irqMask_reg   <= 2'h0;
        end else begin
            if (avsWrite && avsAddress == `ADCSQ_REG_LEN) begin
                lenCode_reg <= avsWriteData[`ADCSQ_LEN_MSB:`ADCSQ_LEN_LSB];
            end
            if (avsWrite && avsAddress == `ADCSQ_REG_MODE) begin
                mode_reg <= avsWriteData[1:0];
            end
            if (avsWrite && avsAddress == `ADCSQ_REG_IRQ_MASK) begin
                irqMask_reg <= avsWriteData[1:0];
            end
            if (wrStart) begin
                startChan_reg <= avsWriteData[`ADCSQ_CHAN_MSB:
                                              `ADCSQ_CHAN_LSB];
                total_reg     <= seqCount(lenCode_reg, narrow);
                doneFlags_reg <= 16'h0000;
            end else if (convEnd) begin
                doneFlags_reg[counter_reg] <= 1'b1;
            end
            // Set wins over read clear
            irqStat_reg[`ADCSQ_IRQ_CONV] <= convEnd ||
                (irqStat_reg[`ADCSQ_IRQ_CONV] && !rdIrq);
            irqStat_reg[`ADCSQ_IRQ_SEQ] <= (convEnd && lastConv) ||
                (irqStat_reg[`ADCSQ_IRQ_SEQ] && !rdIrq);
        end
    end

    // Top counter bit hidden for eight or fewer, also in narrow mode
    assign shownCount = (total_reg <= `ADCSQ_NARROW_HALF) ?
                        {1'b0, counter_reg[2:0]} : counter_reg;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Captured in the waiting cycle, stands at the accepting edge;
    // unmapped reads return zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdPend_reg  <= 1'b0;
            avsReadData <= 32'h00000000;
        end else begin
            rdPend_reg  <= avsWaitRequest;
            avsReadData <= 32'h00000000;
            if (avsWaitRequest) begin
                case (avsAddress)
                    `ADCSQ_REG_LEN:
                        avsReadData <= {28'h0, lenCode_reg};
                    `ADCSQ_REG_START:
                        avsReadData <= {28'h0, startChan_reg};
                    `ADCSQ_REG_STATUS:
                        avsReadData <= {23'h0, seqBusy, convChannel,
                                        shownCount};
                    `ADCSQ_REG_FLAGS:
                        avsReadData <= {16'h0, doneFlags_reg};
                    `ADCSQ_REG_IRQ_STAT:
                        avsReadData <= {30'h0, irqStat_reg};
                    `ADCSQ_REG_IRQ_MASK:
                        avsReadData <= {30'h0, irqMask_reg};
                    `ADCSQ_REG_MODE:
                        avsReadData <= {30'h0, mode_reg};
                    default:
                        avsReadData <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // adcsq_seq_ctrl

/* testbench/adcsq_seq_ctrl_assertions.sv */
`timescale 1ns/10ps
module adcsq_seq_ctrl_assertions (
    input wire        clk,
    input wire        rst_b,
    input wire [3:0]  avsAddress,
    input wire        avsRead,
    input wire        avsWrite,
    input wire [31:0] avsWriteData,
    input wire [31:0] avsReadData,
    input wire        convStart,
    input wire [3:0]  convChannel,
    input wire        seqBusy,
    input wire        irq
);
    // --------
    // Shadow of the programmed sequence
    // --------
    reg  [1:0] modeReg;
    reg  [3:0] lenReg;
    reg  [4:0] expN;
    reg  [4:0] nConv;
    reg  [3:0] lastChan;
    reg  [3:0] firstChan;
    reg        seqNarrow;
    wire       startWr = avsWrite && avsAddress == 4'h1 && !seqBusy;
    wire [4:0] lenN = (lenReg == 4'h0 || (modeReg[0] && lenReg[3])) ?
                      (modeReg[0] ? 5'h08 : 5'h10) : {1'b0, lenReg};
    wire [3:0] nextChan = seqNarrow ? {lastChan[3], lastChan[2:0] + 3'h1} :
                          lastChan + 4'h1;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            modeReg <= 2'h0;
            lenReg <= 4'h0;
            expN <= 5'h10;
            nConv <= 5'h00;
            lastChan <= 4'h0;
            firstChan <= 4'h0;
            seqNarrow <= 1'b0;
        end else begin
            if (avsWrite && avsAddress == 4'h6)
                modeReg <= avsWriteData[1:0];
            if (avsWrite && avsAddress == 4'h0)
                lenReg <= avsWriteData[3:0];
            if (startWr) begin
                expN <= lenN;
                nConv <= 5'h00;
                seqNarrow <= modeReg[0];
                firstChan <= modeReg[0] ?
                    {modeReg[1], avsWriteData[2:0]} : avsWriteData[3:0];
            end else if (convStart)
                nConv <= nConv + 5'h01;
            if (convStart)
                lastChan <= convChannel;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_start_conv: assert property (startWr |-> ##[1:3] convStart)
        else $error("no conversion after start");
    chk_first_chan: assert property (
        convStart && nConv == 5'h00 |-> convChannel == firstChan)
        else $error("first channel wrong");
    chk_chan_step: assert property (
        convStart && nConv != 5'h00 |-> convChannel == nextChan)
        else $error("channel step wrong");
    chk_conv_count: assert property (
        $fell(seqBusy) |-> nConv == expN)
        else $error("conversion count wrong");
    chk_start_pulse: assert property (convStart |=> !convStart)
        else $error("start pulse too long");
    chk_busy_start: assert property (startWr |=> seqBusy)
        else $error("busy not raised");
    chk_status_top: assert property (
        avsRead && avsAddress == 4'h2 && expN <= 5'h08 |=> !avsReadData[3])
        else $error("counter top bit set");
    chk_irq_mask: assert property (avsWrite && avsAddress == 4'h5 &&
        avsWriteData[1:0] == 2'h0 |=> !irq)
        else $error("masked interrupt seen");
    chk_unmapped_read: assert property (
        avsRead && avsAddress > 4'h6 |=> avsReadData == 32'h0)
        else $error("unmapped read not zero");
    cover property (startWr);
    cover property ($fell(seqBusy) && seqNarrow);
    cover property ($rose(irq));
endmodule // adcsq_seq_ctrl_assertions

/* testbench/adcsq_seq_ctrl_test.sv */
`timescale 1ns/10ps
module adcsq_seq_ctrl_test;
    // --------
    // Bench
    // --------
    reg         clk, rst_b, avsRead, avsWrite, convDone;
    reg  [3:0]  avsAddress;
    reg  [31:0] avsWriteData;
    reg  [31:0] rd;
    wire [31:0] avsReadData;
    wire [3:0]  convChannel;
    wire        avsWaitRequest, convStart, seqBusy, irq;
    integer     nFail, checksDone;
    adcsq_seq_ctrl #(.CONV_CYCLES(4)) adcsq_seq_ctrl_i (.clk(clk),
        .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .convDone(convDone), .convStart(convStart),
        .convChannel(convChannel), .seqBusy(seqBusy), .irq(irq));
    task summarize;
        begin
            if (nFail == 0 && checksDone > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task cmp(input [79:0] what, input [31:0] exp, input [31:0] got);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                nFail = nFail + 1;
                $display("unexpected %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    // Idle cycle before each request keeps strobes single-assigned
    task bus(input wr, input [3:0] a, input [31:0] d);
        integer i;
        begin
            @(posedge clk);
            avsAddress <= a;
            avsWriteData <= d;
            avsWrite <= wr;
            avsRead <= !wr;
            @(negedge clk);
            for (i = 0; avsWaitRequest !== 1'b0; i = i + 1) begin
                if (i == 100) begin
                    nFail = nFail + 1;
                    summarize;
                end
                @(negedge clk);
            end
            // Read data stands unchanged up to the accepting edge
            rd = avsReadData;
            @(posedge clk);
            avsWrite <= 1'b0;
            avsRead <= 1'b0;
            @(negedge clk);
        end
    endtask
    task regReset;
        begin
            bus(0, 4'h0, 32'h0);
            cmp("len rst", 32'h0, rd);
            bus(0, 4'h6, 32'h0);
            cmp("mode rst", 32'h0, rd);
            bus(1, 4'hf, 32'h5a);
            bus(0, 4'hf, 32'h0);
            cmp("unmapped", 32'h0, rd);
        end
    endtask
    task runSeq(input [1:0] m, input [3:0] len, input [3:0] ch, input [4:0] n);
        integer i, k;
        reg [3:0] e;
        begin
            bus(1, 4'h6, {30'h0, m});
            bus(1, 4'h0, {28'h0, len});
            bus(1, 4'h1, {28'h0, ch});
            k = 0;
            e = ch;
            if (m[0]) e = {m[1], ch[2:0]};
            for (i = 0; i < 2000 && (seqBusy !== 1'b0 || k == 0); i = i + 1) begin
                @(posedge clk);
                #1;
                if (convStart === 1'b1) begin
                    cmp("channel", e, convChannel);
                    k = k + 1;
                    e = m[0] ? {e[3], e[2:0] + 3'h1} : e + 4'h1;
                end
            end
            if (i == 2000) begin
                nFail = nFail + 1;
                summarize;
            end
            cmp("count", n, k);
            bus(0, 4'h3, 32'h0);
            cmp("flags", (32'h1 << n) - 32'h1, rd);
        end
    endtask
    task statusPoll(input [3:0] len, input [3:0] top);
        integer i;
        reg [3:0] mx;
        begin
            bus(1, 4'h6, 32'h0);
            bus(1, 4'h0, {28'h0, len});
            bus(1, 4'h1, 32'h0);
            mx = 4'h0;
            rd = 32'h100;
            for (i = 0; i < 500 && rd[8] !== 1'b0; i = i + 1) begin
                bus(0, 4'h2, 32'h0);
                if (rd[8] === 1'b1 && rd[3:0] > mx) mx = rd[3:0];
            end
            if (i == 500) begin
                nFail = nFail + 1;
                summarize;
            end
            cmp("count max", top, mx);
        end
    endtask
    // Done pin rise ends a conversion before the internal timer
    task doneEarly;
        integer k;
        begin
            bus(1, 4'h6, 32'h0);
            bus(1, 4'h0, 32'h1);
            bus(1, 4'h1, 32'h0);
            @(posedge clk);
            convDone <= 1'b1;
            @(negedge clk);
            for (k = 0; k < 20 && seqBusy === 1'b1; k = k + 1) begin
                @(negedge clk);
            end
            @(posedge clk);
            convDone <= 1'b0;
            cmp("done cyc", 32'h4, k);
            bus(0, 4'h3, 32'h0);
            cmp("done flag", 32'h1, rd);
        end
    endtask
    task irqCheck;
        begin
            bus(1, 4'h5, 32'h0);
            runSeq(2'h0, 4'h2, 4'h3, 5'h2);
            cmp("irq off", 32'h0, irq);
            bus(1, 4'h5, 32'h2);
            cmp("irq on", 32'h1, irq);
            bus(0, 4'h4, 32'h0);
            cmp("irq stat", 32'h3, rd & 32'h3);
            cmp("irq clr", 32'h0, irq);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        convDone = 1'b0;
        avsAddress = 4'h0;
        avsWriteData = 32'h0;
        nFail = 0;
        checksDone = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        regReset;
        runSeq(2'h0, 4'h0, 4'he, 5'h10);
        runSeq(2'h0, 4'hf, 4'h1, 5'h0f);
        runSeq(2'h0, 4'h1, 4'h9, 5'h01);
        runSeq(2'h1, 4'h0, 4'h5, 5'h08);
        runSeq(2'h1, 4'h9, 4'h2, 5'h08);
        runSeq(2'h3, 4'h3, 4'h5, 5'h03);
        runSeq(2'h3, 4'h7, 4'h6, 5'h07);
        statusPoll(4'h8, 4'h7);
        statusPoll(4'h0, 4'hf);
        doneEarly;
        irqCheck;
        summarize;
    end
endmodule // adcsq_seq_ctrl_test
bind adcsq_seq_ctrl adcsq_seq_ctrl_assertions adcsq_seq_ctrl_assertions_i (
    .clk(clk), .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .convStart(convStart),
    .convChannel(convChannel), .seqBusy(seqBusy), .irq(irq));
